// ---- verilog/drab_pkg.sv ----
/*
 Constants, command codes and helpers for the row-activate and burst-read
 command decoder. Assumes a 64 ns link clock; timings below are plain defaults.
*/
package drab_pkg;
    localparam int LINK_CK_NS = 64;
    localparam int T_RCD_NS   = 18;
    localparam int T_RAS_NS   = 42;
    localparam int T_RPPB_NS  = 18;
    localparam int T_RPAB_NS  = 21;
    localparam int T_RC_NS    = 60;
    localparam int T_RRD_NS   = 10;
    localparam int T_FAW_NS   = 40;

    // least times round up, never below one cycle
    function automatic int to_cyc(input int t_ns);
        int c;
        c = (t_ns + LINK_CK_NS - 1) / LINK_CK_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [7:0] RCD_CYC  = 8'(to_cyc(T_RCD_NS));
    localparam logic [7:0] RAS_CYC  = 8'(to_cyc(T_RAS_NS));
    localparam logic [7:0] RPPB_CYC = 8'(to_cyc(T_RPPB_NS));
    localparam logic [7:0] RPAB_CYC = 8'(to_cyc(T_RPAB_NS));
    localparam logic [7:0] RC_CYC   = 8'(to_cyc(T_RC_NS));
    localparam logic [7:0] RRD_CYC  = 8'(to_cyc(T_RRD_NS));
    localparam logic [7:0] FAW_CYC  = 8'(to_cyc(T_FAW_NS));
    localparam logic [7:0] AGE_SAT  = 8'hff;

    localparam int          BANKS        = 8;
    localparam int          FAW_ACTS     = 4;
    localparam logic [7:0]  RL_RESET     = 8'h08;
    localparam logic [7:0]  RL_MIN       = 8'h03;
    localparam logic [7:0]  PRE_LAST     = 8'h01;
    localparam logic [5:0]  BL_SHORT     = 6'h10;
    localparam logic [5:0]  BL_LONG      = 6'h20;
    localparam logic [5:0]  STROBE_MR_MA = 6'h01;
    localparam logic [5:0]  LAT_MR_MA    = 6'h02;
    localparam int          OPT_PRE_BIT  = 3;
    localparam int          OPT_POST_BIT = 7;

    localparam logic [4:0] CODE_RD1  = 5'h02;
    localparam logic [4:0] CODE_WR1  = 5'h04;
    localparam logic [4:0] CODE_MWR1 = 5'h0c;
    localparam logic [4:0] CODE_CAS2 = 5'h12;
    localparam logic [4:0] CODE_PRE  = 5'h10;
    localparam logic [4:0] CODE_REF  = 5'h08;
    localparam logic [4:0] CODE_MRW1 = 5'h06;
    localparam logic [4:0] CODE_MRW2 = 5'h16;

    typedef enum logic [3:0] {
        CMD_NONE, CMD_ACT1, CMD_ACT2, CMD_RD1, CMD_WR1, CMD_CAS2,
        CMD_PRE, CMD_REF, CMD_MRW1, CMD_MRW2, CMD_OTHER
    } drab_cmd_t;

    typedef enum logic [2:0] {RD_IDLE, RD_WAIT, RD_PRE, RD_DATA, RD_POST} drab_rd_t;

    function automatic drab_cmd_t decode_cmd(input logic [5:0] ca);
        drab_cmd_t c;
        c = CMD_OTHER;
        if (ca[1:0] == 2'b01) begin
            c = CMD_ACT1;
        end else if (ca[1:0] == 2'b11) begin
            c = CMD_ACT2;
        end else begin
            case (ca[4:0])
                CODE_RD1:  c = CMD_RD1;
                CODE_WR1:  c = CMD_WR1;
                CODE_MWR1: c = CMD_WR1;
                CODE_CAS2: c = CMD_CAS2;
                CODE_PRE:  c = CMD_PRE;
                CODE_REF:  c = CMD_REF;
                CODE_MRW1: c = CMD_MRW1;
                CODE_MRW2: c = CMD_MRW2;
                default:   c = CMD_OTHER;
            endcase
        end
        return c;
    endfunction

    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == AGE_SAT) ? v : v + 8'h01;
    endfunction
endpackage

// ---- verilog/drab_row_if.sv ----
/*
 Port bundle between the command decoder and the open-row store.
 Both ends run on the link clock.
*/
interface drab_row_if #(parameter int AW = 3, parameter int DW = 16) (input wire logic clk);
    logic          we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport mem_mp (input clk, we, waddr, wdata, raddr, output rdata);
    modport ctl_mp (input rdata, output we, waddr, wdata, raddr);
endinterface

// ---- verilog/drab_row_mem.sv ----
/*
 Open-row store: one row address per bank, registered read.
 Assumes writer and reader share the link clock.
*/
module drab_row_mem
    import drab_pkg::*;
#(
    parameter int AW = 3,
    parameter int DW = 16
) (
    drab_row_if.mem_mp rif
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge rif.clk) begin
        if (rif.we) begin
            mem[rif.waddr] <= rif.wdata;
        end
    end

    always_ff @(posedge rif.clk) begin
        rif.rdata <= mem[rif.raddr];
    end
endmodule // drab_row_mem

// ---- verilog/drab_core.sv ----
/*
 Device-side command decoder for two-part row activation, bank timing
 checks and burst reads with strobe preamble and postamble.
 Assumes the controller drives cs and ca on the link clock; status crosses
 to sys_clk through synchronisers.
*/
module drab_core
    import drab_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        link_ck,
    input  wire logic        cs,
    input  wire logic [5:0]  ca,
    output logic [15:0]      dq_out,
    output logic             dq_oe,
    output logic             dqs_t,
    output logic             dqs_c,
    output logic             dqs_oe,
    output logic [7:0]       bank_open_st,
    output logic             pre_toggle_st,
    output logic             ext_post_st,
    output logic             seq_error,
    input  wire logic        error_clear
);
    logic [2:0]       lrst;
    logic             link_rstn;
    logic             in_second;
    drab_cmd_t        first_cmd;
    drab_cmd_t        chain;
    drab_cmd_t        cmd_now;
    drab_cmd_t        next_chain;
    logic [5:0]       first_ca;
    logic [2:0]       act_bank;
    logic [5:0]       row_hi;
    logic [2:0]       cas_bank;
    logic             cas_read;
    logic             cas_long;
    logic             cas_ap;
    logic             cas_c9;
    logic [5:0]       mrw_ma;
    logic             mrw_op7;
    logic [7:0]       rl;
    logic             pre_toggle;
    logic             ext_post;
    logic [7:0]       bank_open;
    logic [7:0]       act_age [BANKS];
    logic [7:0]       pre_age [BANKS];
    logic [7:0]       pre_ab;
    logic [7:0]       rrd_age;
    logic [7:0]       faw_age [FAW_ACTS];
    logic [1:0]       faw_ptr;
    logic             err_tgl;
    logic [2:0]       bank_sel;
    logic             ab;
    logic [15:0]      new_row;
    logic [9:0]       col_start;
    logic [7:0]       mrw_op;
    logic             act1_go, act2_go, rdwr1_go, cas2_go, pre_go, ref_go, mrw1_go, mrw2_go;
    logic             chain_err, act_err, cas_err, pre_err, ref_err, err_ev;
    logic             act_ok, rd_start, faw_push, cas_close;
    logic [7:0]       close_vec;
    logic [7:0]       ras_short;
    logic [7:0]       act_hit;

    drab_rd_t         rd_state, next_rd_state;
    logic [7:0]       rd_cnt, next_cnt;
    logic [5:0]       beat, next_beat;
    logic [9:0]       rd_col;
    logic [2:0]       rd_bank;
    logic             rd_long;
    logic [5:0]       burst_len;
    logic [15:0]      beat_word;
    logic             next_dqs_t, next_dqs_oe, next_dq_oe;
    logic [15:0]      next_dq;

    drab_row_if #(.AW(3), .DW(16)) rif (.clk(link_ck));

    drab_row_mem #(.AW(3), .DW(16)) u_rows (.rif(rif.mem_mp));

    // link-domain reset, released once two stages agree
    always_ff @(posedge link_ck) begin
        lrst <= {lrst[1:0], rstn};
    end
    assign link_rstn = lrst[2] & lrst[1];

    // command decode and field extraction
    assign cmd_now   = decode_cmd(ca);
    assign bank_sel  = ca[2:0];
    assign ab        = first_ca[5];
    assign new_row   = {row_hi, first_ca[5:2], ca};
    assign col_start = {cas_c9, first_ca[5], ca, 2'b00};
    assign mrw_op    = {mrw_op7, first_ca[5], ca};

    assign act1_go  = in_second && first_cmd == CMD_ACT1;
    assign act2_go  = in_second && first_cmd == CMD_ACT2 && chain == CMD_ACT2;
    assign rdwr1_go = in_second && (first_cmd == CMD_RD1 || first_cmd == CMD_WR1);
    assign cas2_go  = in_second && first_cmd == CMD_CAS2 && chain == CMD_CAS2;
    assign pre_go   = in_second && first_cmd == CMD_PRE;
    assign ref_go   = in_second && first_cmd == CMD_REF;
    assign mrw1_go  = in_second && first_cmd == CMD_MRW1;
    assign mrw2_go  = in_second && first_cmd == CMD_MRW2 && chain == CMD_MRW2;

    assign next_chain = (first_cmd == CMD_ACT1) ? CMD_ACT2 :
                        (first_cmd == CMD_RD1 || first_cmd == CMD_WR1) ? CMD_CAS2 :
                        (first_cmd == CMD_MRW1) ? CMD_MRW2 : CMD_NONE;

    // second parts must follow their first parts directly
    assign chain_err = (in_second && chain != CMD_NONE && first_cmd != chain)
        || (in_second && chain == CMD_NONE
            && first_cmd inside {CMD_ACT2, CMD_CAS2, CMD_MRW2})
        || (!in_second && !cs && chain != CMD_NONE);

    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            ras_short[b] = bank_open[b] && act_age[b] < RAS_CYC;
            act_hit[b]   = act_ok && act_bank == 3'(b);
            close_vec[b] = (pre_go && (ab || bank_sel == 3'(b)))
                        || (cas_close && cas_bank == 3'(b));
        end
    end

    assign act_err = act2_go && (bank_open[act_bank]
        || pre_age[act_bank] < (pre_ab[act_bank] ? RPAB_CYC : RPPB_CYC)
        || act_age[act_bank] < RC_CYC
        || rrd_age < RRD_CYC
        || faw_age[faw_ptr] < FAW_CYC);
    assign cas_err = cas2_go && (!bank_open[cas_bank]
        || act_age[cas_bank] < RCD_CYC
        || (cas_read && rd_state != RD_IDLE));
    assign pre_err = pre_go && (ab ? |ras_short : ras_short[bank_sel]);
    assign ref_err = ref_go && (ab ? |bank_open : bank_open[bank_sel]);
    assign err_ev  = chain_err || act_err || cas_err || pre_err || ref_err;

    assign act_ok    = act2_go && !act_err;
    assign rd_start  = cas2_go && cas_read && !cas_err;
    assign cas_close = cas2_go && cas_ap && !cas_err;
    assign faw_push  = act_ok || (ref_go && !ab);

    // two-cycle command framing: select high opens, next edge carries payload
    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            in_second <= 1'b0;
            first_cmd <= CMD_NONE;
            first_ca  <= 6'h00;
            chain     <= CMD_NONE;
        end else if (in_second) begin
            in_second <= 1'b0;
            chain     <= next_chain;
        end else if (cs) begin
            in_second <= 1'b1;
            first_cmd <= cmd_now;
            first_ca  <= ca;
        end else if (chain_err) begin
            chain     <= CMD_NONE;
        end
    end

    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            act_bank <= 3'h0;
            row_hi   <= 6'h00;
            cas_bank <= 3'h0;
            cas_read <= 1'b0;
            cas_long <= 1'b0;
            cas_ap   <= 1'b0;
            cas_c9   <= 1'b0;
        end else if (act1_go) begin
            act_bank <= bank_sel;
            row_hi   <= {first_ca[5:2], ca[5:4]};
        end else if (rdwr1_go) begin
            cas_bank <= bank_sel;
            cas_read <= first_cmd == CMD_RD1;
            cas_long <= first_ca[5];
            cas_ap   <= ca[5];
            cas_c9   <= ca[4];
        end
    end

    // mode register writes: strobe options and read latency
    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            mrw_ma     <= 6'h00;
            mrw_op7    <= 1'b0;
            rl         <= RL_RESET;
            pre_toggle <= 1'b0;
            ext_post   <= 1'b0;
        end else if (mrw1_go) begin
            mrw_ma  <= ca;
            mrw_op7 <= first_ca[5];
        end else if (mrw2_go && mrw_ma == STROBE_MR_MA) begin
            pre_toggle <= mrw_op[OPT_PRE_BIT];
            ext_post   <= mrw_op[OPT_POST_BIT];
        end else if (mrw2_go && mrw_ma == LAT_MR_MA) begin
            rl <= (mrw_op < RL_MIN) ? RL_MIN : mrw_op;
        end
    end

    // per-bank open state and age counters
    always_ff @(posedge link_ck) begin
        for (int b = 0; b < BANKS; b++) begin
            if (!link_rstn) begin
                bank_open[b] <= 1'b0;
                act_age[b]   <= AGE_SAT;
                pre_age[b]   <= AGE_SAT;
                pre_ab[b]    <= 1'b0;
            end else begin
                bank_open[b] <= act_hit[b] | (bank_open[b] & ~close_vec[b]);
                act_age[b]   <= act_hit[b] ? 8'h00 : sat_inc(act_age[b]);
                pre_age[b]   <= close_vec[b] ? 8'h00 : sat_inc(pre_age[b]);
                pre_ab[b]    <= close_vec[b] ? (pre_go && ab) : pre_ab[b];
            end
        end
    end

    // activation spacing and rolling four-activation window
    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            rrd_age <= AGE_SAT;
            faw_ptr <= 2'h0;
            for (int i = 0; i < FAW_ACTS; i++) faw_age[i] <= AGE_SAT;
        end else begin
            rrd_age <= act_ok ? 8'h00 : sat_inc(rrd_age);
            for (int i = 0; i < FAW_ACTS; i++) begin
                faw_age[i] <= (faw_push && faw_ptr == 2'(i)) ? 8'h00 : sat_inc(faw_age[i]);
            end
            if (faw_push) faw_ptr <= faw_ptr + 2'h1;
        end
    end

    assign rif.we    = act_ok;
    assign rif.waddr = act_bank;
    assign rif.wdata = new_row;
    assign rif.raddr = rd_bank;

    // read burst sequencing
    assign burst_len = rd_long ? BL_LONG : BL_SHORT;
    assign beat_word = {rif.rdata[5:0], 10'(rd_col + {4'h0, beat})};

    always_comb begin
        next_rd_state = rd_state;
        next_cnt      = rd_cnt;
        next_beat     = beat;
        next_dqs_t    = 1'b0;
        next_dqs_oe   = 1'b0;
        next_dq_oe    = 1'b0;
        next_dq       = 16'h0000;
        case (rd_state)
            RD_IDLE: if (rd_start) begin
                next_rd_state = RD_WAIT;
                next_cnt      = rl - RL_MIN;
                next_beat     = 6'h00;
            end
            RD_WAIT: if (rd_cnt == 8'h00) begin
                next_rd_state = RD_PRE;
                next_cnt      = PRE_LAST;
                next_dqs_oe   = 1'b1;
                next_dqs_t    = pre_toggle;
            end else begin
                next_cnt = rd_cnt - 8'h01;
            end
            RD_PRE: begin
                next_dqs_oe = 1'b1;
                if (rd_cnt != 8'h00) begin
                    next_cnt = rd_cnt - 8'h01;
                end else begin
                    next_rd_state = RD_DATA;
                    next_dqs_t    = 1'b1;
                    next_dq_oe    = 1'b1;
                    next_dq       = beat_word;
                    next_beat     = beat + 6'h01;
                end
            end
            RD_DATA: begin
                next_dqs_oe = 1'b1;
                if (beat == burst_len) begin
                    next_rd_state = RD_POST;
                    next_dqs_t    = ext_post;
                    next_cnt      = {7'h00, ext_post};
                end else begin
                    next_dq_oe = 1'b1;
                    next_dqs_t = ~beat[0];
                    next_dq    = beat_word;
                    next_beat  = beat + 6'h01;
                end
            end
            RD_POST: if (rd_cnt == 8'h00) begin
                next_rd_state = RD_IDLE;
            end else begin
                next_dqs_oe = 1'b1;
                next_cnt    = rd_cnt - 8'h01;
            end
            default: next_rd_state = RD_IDLE;
        endcase
    end

    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            rd_state <= RD_IDLE;
            rd_cnt   <= 8'h00;
            beat     <= 6'h00;
            dqs_t    <= 1'b0;
            dqs_c    <= 1'b1;
            dqs_oe   <= 1'b0;
            dq_oe    <= 1'b0;
            dq_out   <= 16'h0000;
        end else begin
            rd_state <= next_rd_state;
            rd_cnt   <= next_cnt;
            beat     <= next_beat;
            dqs_t    <= next_dqs_t;
            dqs_c    <= ~next_dqs_t;
            dqs_oe   <= next_dqs_oe;
            dq_oe    <= next_dq_oe;
            dq_out   <= next_dq;
        end
    end

    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            rd_col  <= 10'h000;
            rd_bank <= 3'h0;
            rd_long <= 1'b0;
        end else if (rd_start) begin
            rd_col  <= col_start;
            rd_bank <= cas_bank;
            rd_long <= cas_long;
        end
    end

    always_ff @(posedge link_ck) begin
        if (!link_rstn) begin
            err_tgl <= 1'b0;
        end else if (err_ev) begin
            err_tgl <= ~err_tgl;
        end
    end

    // crossing to sys_clk: level vector and error toggle
    logic [9:0] lv_s1, lv_s2, lv_s3, lv;
    logic [2:0] e_s;
    logic       err_pulse;

    always_ff @(posedge sys_clk) begin
        lv_s1 <= {ext_post, pre_toggle, bank_open};
        lv_s2 <= lv_s1;
        lv_s3 <= lv_s2;
        e_s   <= {e_s[1:0], err_tgl};
    end
    assign err_pulse = e_s[1] ^ e_s[2];

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lv        <= 10'h000;
            seq_error <= 1'b0;
        end else begin
            lv        <= (lv_s2 & lv_s3) | (lv & (lv_s2 ^ lv_s3));
            seq_error <= err_pulse | (seq_error & ~error_clear);
        end
    end

    assign bank_open_st  = lv[7:0];
    assign pre_toggle_st = lv[8];
    assign ext_post_st   = lv[9];
endmodule // drab_core

// ---- sim/drab_checker.sv ----
/* Pin assertions for drab_core: strobe preamble, beats, postamble.
   Bound into drab_core; all checks run on link_ck. */
module drab_checker
    import drab_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        link_ck,
    input wire logic        cs,
    input wire logic [5:0]  ca,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        dqs_t,
    input wire logic        dqs_c,
    input wire logic        dqs_oe,
    input wire logic [7:0]  bank_open_st,
    input wire logic        pre_toggle_st,
    input wire logic        ext_post_st,
    input wire logic        seq_error,
    input wire logic        error_clear
);
    logic [7:0] beats;
    logic [9:0] col;
    logic [2:0] lrst_s;
    logic       link_ok;
    assign col = dq_out[9:0];
    // rstn seen on link_ck, as the core's own link reset
    always_ff @(posedge link_ck) begin
        lrst_s <= {lrst_s[1:0], rstn};
    end
    assign link_ok = lrst_s[2] & lrst_s[1];
    // beats driven so far in the current burst
    always_ff @(posedge link_ck) begin
        if (!link_ok) begin
            beats <= 8'h00;
        end else begin
            beats <= dq_oe ? beats + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge link_ck); endclocking
    default disable iff (!rstn || !link_ok);
    sequence pre_s;
        dqs_oe && !dq_oe ##1 dqs_oe && !dq_oe && !dqs_t;
    endsequence
    sequence post_s;
        dqs_oe && dqs_t == ext_post_st ##1 dqs_oe == ext_post_st ##1 !dqs_oe;
    endsequence
    chk_strobe_pair: assert property (dqs_c == !dqs_t)
        else $error("dqs_c not inverse of dqs_t");
    chk_preamble_form: assert property (
        $rose(dqs_oe) |-> dqs_t == pre_toggle_st ##0 pre_s ##1 dq_oe && dqs_t)
        else $error("bad read preamble");
    chk_beat_toggle: assert property (dq_oe && $past(dq_oe) |-> dqs_t != $past(dqs_t))
        else $error("strobe did not toggle per beat");
    chk_col_step: assert property (
        dq_oe && $past(dq_oe) |-> col == $past(col) + 10'h001)
        else $error("column did not step by one");
    chk_col_align: assert property ($rose(dq_oe) |-> col[1:0] == 2'b00)
        else $error("burst start not a multiple of four");
    chk_dq_framed: assert property (dq_oe |-> dqs_oe)
        else $error("data driven without strobe");
    chk_burst_len: assert property ($fell(dq_oe) |-> beats == {2'b00, BL_SHORT} || beats == {2'b00, BL_LONG})
        else $error("burst length not 16 or 32");
    chk_postamble: assert property ($fell(dq_oe) |-> post_s)
        else $error("bad read postamble");
endmodule // drab_checker

bind drab_core drab_checker i_drab_checker (
    .sys_clk(sys_clk), .rstn(rstn), .link_ck(link_ck), .cs(cs), .ca(ca),
    .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t(dqs_t), .dqs_c(dqs_c), .dqs_oe(dqs_oe),
    .bank_open_st(bank_open_st), .pre_toggle_st(pre_toggle_st),
    .ext_post_st(ext_post_st), .seq_error(seq_error), .error_clear(error_clear)
);

// ---- sim/drab_host.sv ----
/* Controller model: free link clock, command parts on cs and ca.
   Driven through its tasks by the bench. */
module drab_host
    import drab_pkg::*;
(
    output logic       link_ck,
    output logic       cs,
    output logic [5:0] ca
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        link_ck = 1'b0;
        cs = 1'b0;
        ca = 6'h00;
        #13;
        forever #32 link_ck = ~link_ck;
    end
    // two cycles a command clear all one-cycle spacings
    task automatic cmd(input logic [5:0] a, input logic [5:0] b);
        @(posedge link_ck);
        #2 cs = 1'b1;
        ca = a;
        @(posedge link_ck);
        #2 cs = 1'b0;
        ca = b;
    endtask
    // deselect; payload no longer held
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge link_ck);
            #2 ca = ~ca;
        end
    endtask
    task automatic act(input logic [2:0] bank, input logic [15:0] row);
        cmd({row[15:12], 2'b01}, {row[11:10], 1'b0, bank});
        cmd({row[9:6], 2'b11}, row[5:0]);
    endtask
    task automatic rd(input logic [2:0] bank, input logic [9:0] col, input logic bl);
        cmd({bl, CODE_RD1}, {1'b0, col[9], 1'b0, bank});
        cmd({col[8], CODE_CAS2}, col[7:2]);
    endtask
    task automatic mode_reg_write_cmd(input logic [5:0] ma, input logic [7:0] op);
        cmd({op[7], CODE_MRW1}, ma);
        cmd({op[6], CODE_MRW2}, op[5:0]);
    endtask
endmodule // drab_host

// ---- sim/test_drab_row_activate_burst_read.sv ----
/* Bench for drab_core: activates, reads, options, refusals.
   Uses drab_host as the controller on the link side. */
module test_drab_row_activate_burst_read
    import drab_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk, rstn, link_ck, cs, error_clear, dq_oe, dqs_t, dqs_oe;
    logic        pre_toggle_st, ext_post_st, seq_error;
    logic [5:0]  ca;
    logic [15:0] dq_out;
    logic [7:0]  bank_open_st;
    int          errors, checked, rl;

    drab_core i_drab_core (
        .sys_clk(sys_clk), .rstn(rstn), .link_ck(link_ck), .cs(cs), .ca(ca),
        .dq_out(dq_out), .dq_oe(dq_oe), .dqs_t(dqs_t), .dqs_c(), .dqs_oe(dqs_oe),
        .bank_open_st(bank_open_st), .pre_toggle_st(pre_toggle_st),
        .ext_post_st(ext_post_st), .seq_error(seq_error), .error_clear(error_clear)
    );
    drab_host i_drab_host (.link_ck(link_ck), .cs(cs), .ca(ca));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic sys_wait();
        repeat (12) @(posedge sys_clk);
        #2;
    endtask

    task automatic errchk();
        sys_wait();
        chk("seq_error", 16'h0001, 16'(seq_error));
        error_clear = 1'b1;
        @(posedge sys_clk);
        #2 error_clear = 1'b0;
        sys_wait();
        chk("seq_error", 16'h0000, 16'(seq_error));
    endtask

    // edge 0 takes the column part; walk every edge to the end of postamble
    task automatic burst(input logic [5:0] row, input logic [9:0] col, input int bl,
                         input logic pre, input logic ext);
        int   k, j, post;
        logic t;
        post = ext ? 2 : 1;
        @(posedge link_ck);
        for (k = 1; k <= rl + bl + post; k++) begin
            @(posedge link_ck);
            #2 j = k - rl;
            t = (j == -2) ? pre : (j >= 0 && j < bl) ? ~j[0] : (j == bl) ? ext : 1'b0;
            chk("dqs_oe", 16'(j >= -2 && j < bl + post), 16'(dqs_oe));
            chk("dq_oe", 16'(j >= 0 && j < bl), 16'(dq_oe));
            if (j >= -2 && j < bl + post) chk("dqs_t", 16'(t), 16'(dqs_t));
            if (j >= 0 && j < bl) chk("dq_out", {row, 10'(col + j)}, dq_out);
        end
    endtask

    initial begin
        #300000;
        errors++;
        test_done();
    end

    initial begin
        rstn = 1'b0;
        error_clear = 1'b0;
        errors = 0;
        checked = 0;
        rl = 8;
        repeat (8) @(posedge sys_clk);
        #2 rstn = 1'b1;
        i_drab_host.idle(4);
        chk("pre_toggle_st", 16'h0000, 16'(pre_toggle_st));
        chk("ext_post_st", 16'h0000, 16'(ext_post_st));
        i_drab_host.act(3'h3, 16'ha5c9);
        sys_wait();
        chk("bank_open_st", 16'h0008, 16'(bank_open_st));
        i_drab_host.rd(3'h3, 10'h3ec, 1'b0);
        burst(6'h09, 10'h3ec, 16, 1'b0, 1'b0);
        i_drab_host.mode_reg_write_cmd(STROBE_MR_MA, 8'h88);
        i_drab_host.mode_reg_write_cmd(LAT_MR_MA, 8'h02);
        rl = 3;
        sys_wait();
        chk("pre_toggle_st", 16'h0001, 16'(pre_toggle_st));
        chk("ext_post_st", 16'h0001, 16'(ext_post_st));
        i_drab_host.rd(3'h3, 10'h010, 1'b1);
        burst(6'h09, 10'h010, 32, 1'b1, 1'b1);
        i_drab_host.rd(3'h5, 10'h000, 1'b0);
        errchk();
        i_drab_host.cmd({4'h0, 2'b01}, 6'h06);
        i_drab_host.idle(2);
        errchk();
        i_drab_host.act(3'h6, 16'h0012);
        sys_wait();
        chk("bank_open_st", 16'h0048, 16'(bank_open_st));
        i_drab_host.act(3'h6, 16'h0034);
        errchk();
        i_drab_host.cmd({1'b0, CODE_REF}, 6'h06);
        errchk();
        i_drab_host.cmd({1'b0, CODE_PRE}, 6'h03);
        i_drab_host.idle(1);
        sys_wait();
        chk("bank_open_st", 16'h0040, 16'(bank_open_st));
        i_drab_host.cmd({1'b0, CODE_WR1}, 6'h26);
        i_drab_host.cmd({1'b0, CODE_CAS2}, 6'h00);
        sys_wait();
        chk("bank_open_st", 16'h0000, 16'(bank_open_st));
        i_drab_host.act(3'h1, 16'h0001);
        i_drab_host.cmd({1'b1, CODE_PRE}, 6'h02);
        i_drab_host.idle(1);
        sys_wait();
        chk("bank_open_st", 16'h0000, 16'(bank_open_st));
        chk("seq_error", 16'h0000, 16'(seq_error));
        test_done();
    end
endmodule // test_drab_row_activate_burst_read
